// *** rtl/vam_defines.svh ***
// Constants of the alarm mapping control block: offsets, fields, resets, codes.
// Included by the package users; holds definitions only.
`ifndef VAM_DEFINES_SVH
`define VAM_DEFINES_SVH

`define VAM_NUM_CH 7
`define VAM_ADDR_W 12
// Per-channel region: byte address = channel * stride + index * 4
`define VAM_CH_STRIDE 12'h020
`define VAM_IDX_XMAP 3'h1
`define VAM_IDX_RDI 3'h2
// Global registers
`define VAM_GLOBAL_PAGE 8'h10
`define VAM_OFS_MODE 2'h0
`define VAM_OFS_STATUS 2'h1
`define VAM_OFS_MASK 2'h2
`define VAM_OFS_LIVE 2'h3
// Cross-map control fields
`define VAM_XMAP_RFI_YEL 2
`define VAM_XMAP_YEL_RFI 1
`define VAM_XMAP_LAIS_VAIS 0
`define VAM_XMAP_WMASK 8'h07
// RDI control fields
`define VAM_RDI_VPD 7
`define VAM_RDI_VSD 6
`define VAM_RDI_VCD 5
`define VAM_RDI_RSVD 4
`define VAM_RDI_SEL 3
`define VAM_RDI_LBL_AIS 2
`define VAM_RDI_WMASK 8'hEC
// Reset values
`define VAM_XMAP_RST 8'h00
`define VAM_RDI_RST 8'h00
`define VAM_MODE_RST 32'h0000_0000
// Status layout: yellow rise, VT AIS rise, DS1 AIS rise
`define VAM_ST_YEL_LSB 0
`define VAM_ST_VAIS_LSB 8
`define VAM_ST_DAIS_LSB 16
`define VAM_ST_W 24
// Mode layout: datacom per channel, byte-sync per channel
`define VAM_MODE_DCOM_LSB 0
`define VAM_MODE_BSYNC_LSB 8
// Three-bit RDI codes
`define VAM_RDI_CODE_NONE 3'h1
`define VAM_RDI_CODE_PD 3'h2
`define VAM_RDI_CODE_SD 3'h5
`define VAM_RDI_CODE_CD 3'h6

`endif

// *** rtl/vam_pkg.sv ***
// Types shared by the alarm mapping control block.
// Assumes vam_defines.svh for numeric constants.
package vam_pkg;

  typedef enum logic [1:0] {
    VAM_RESP_OKAY = 2'b00,
    VAM_RESP_SLVERR = 2'b10
  } vam_resp_type;

endpackage

// *** rtl/vam_chan_map.sv ***
// One channel's alarm crossing and RDI code selection, purely combinational.
// Assumes control bits and alarm indications on the same clock as the caller.
`timescale 1ns/1ps
`include "vam_defines.svh"

module vam_chan_map (
  input wire logic datacom,
  input wire logic byte_sync,
  input wire logic [7:0] xmap,
  input wire logic [7:0] rdi_ctrl,
  input wire logic rfi_rx,
  input wire logic yellow_rx,
  input wire logic line_ais_det,
  input wire logic label_mismatch,
  input wire logic [2:0] auto_rdi,
  output logic yellow_tx,
  output logic rfi_ins,
  output logic vt_ais,
  output logic ds1_ais,
  output logic [2:0] rdi_code
);

  wire logic map_ok;
  wire logic force_sel;
  wire logic [2:0] forced_code;

  assign map_ok = ~datacom;
  assign yellow_tx = map_ok & xmap[`VAM_XMAP_RFI_YEL] & rfi_rx;
  assign rfi_ins = map_ok & xmap[`VAM_XMAP_YEL_RFI] & yellow_rx;
  assign vt_ais = map_ok & byte_sync & xmap[`VAM_XMAP_LAIS_VAIS] & line_ais_det;
  assign ds1_ais = rdi_ctrl[`VAM_RDI_LBL_AIS] & label_mismatch;

  // Server above connectivity above payload if several are set
  assign forced_code =
    rdi_ctrl[`VAM_RDI_VSD] ? `VAM_RDI_CODE_SD :
    rdi_ctrl[`VAM_RDI_VCD] ? `VAM_RDI_CODE_CD :
    rdi_ctrl[`VAM_RDI_VPD] ? `VAM_RDI_CODE_PD :
    `VAM_RDI_CODE_NONE;
  assign force_sel = rdi_ctrl[`VAM_RDI_SEL];
  assign rdi_code = force_sel ? forced_code : auto_rdi;

endmodule

// *** rtl/vam_alarm_map.sv ***
// Seven-channel alarm mapping control bank with AXI4-Lite register access.
// Assumes alarm indications come from logic on aclk; outputs feed the mapper.
//
// Behaviour
// - With RFI-to-yellow enabled, received V5 RFI signals DS1 Yellow on highway.
// - Datacom mode disables RFI/yellow and DS1-AIS-to-VT-AIS mappings.
// - With yellow-to-RFI enabled, highway DS1 Yellow inserts RFI in outgoing V5.
// - In byte-sync mode with enable set, detected DS1 AIS generates VT AIS.
// - Bit 7 with force select one sends payload-defect RDI continuously.
// - Bit 6 with force select one sends server-defect RDI continuously.
// - Bit 5 with force select one sends connectivity-defect RDI continuously.
// - Force select zero derives the RDI code from faults or ring port.
// - Force select one sends requested RDI codes, overriding autonomous generation.
// - With bit 2 set, a signal label mismatch drives DS1 AIS.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "vam_defines.svh"

module vam_alarm_map #(
  parameter int NUM_CH = `VAM_NUM_CH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`VAM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`VAM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_CH-1:0] rfi_rx,
  input wire logic [NUM_CH-1:0] yellow_rx,
  input wire logic [NUM_CH-1:0] line_ais_det,
  input wire logic [NUM_CH-1:0] label_mismatch,
  input wire logic [3*NUM_CH-1:0] auto_rdi,
  output logic [NUM_CH-1:0] yellow_tx,
  output logic [NUM_CH-1:0] rfi_ins,
  output logic [NUM_CH-1:0] vt_ais,
  output logic [NUM_CH-1:0] ds1_ais,
  output logic [3*NUM_CH-1:0] rdi_code,
  output logic irq
);

  // Register storage: one cross-map and RDI entry per channel, plus global mode, status and mask
  logic [7:0] xmap_r [0:NUM_CH-1];
  logic [7:0] rdi_r [0:NUM_CH-1];
  logic [31:0] mode_r;
  logic [`VAM_ST_W-1:0] status_r;
  logic [`VAM_ST_W-1:0] mask_r;

  // Write channel state
  logic aw_held_r;
  logic w_held_r;
  logic [`VAM_ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  wire logic aw_take;
  wire logic w_take;
  wire logic b_done;
  wire logic do_write;
  wire logic ar_take;
  wire logic r_done;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign b_done = s_axi_bvalid & s_axi_bready;
  assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign r_done = s_axi_rvalid & s_axi_rready;

  // Write address decode
  wire logic [2:0] w_ch;
  wire logic [2:0] w_idx;
  wire logic w_in_ch;
  wire logic w_is_glob;
  wire logic w_xmap;
  wire logic w_rdi;
  wire logic w_mode;
  wire logic w_stat;
  wire logic w_mask;
  wire logic w_hit;
  wire logic [31:0] wmask;
  wire logic [31:0] wbits;

  assign w_ch = awaddr_r[7:5];
  assign w_idx = awaddr_r[4:2];
  assign w_in_ch = (awaddr_r[11:8] == 4'h0) && (32'(w_ch) < NUM_CH);
  assign w_is_glob = awaddr_r[11:4] == `VAM_GLOBAL_PAGE;
  assign w_xmap = w_in_ch && (w_idx == `VAM_IDX_XMAP);
  assign w_rdi = w_in_ch && (w_idx == `VAM_IDX_RDI);
  assign w_mode = w_is_glob && (awaddr_r[3:2] == `VAM_OFS_MODE);
  assign w_stat = w_is_glob && (awaddr_r[3:2] == `VAM_OFS_STATUS);
  assign w_mask = w_is_glob && (awaddr_r[3:2] == `VAM_OFS_MASK);
  assign w_hit = w_xmap | w_rdi | w_mode | w_stat | w_mask |
    (w_is_glob && (awaddr_r[3:2] == `VAM_OFS_LIVE));
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign wbits = wdata_r & wmask;

  // Read address decode
  wire logic [2:0] r_ch;
  wire logic [2:0] r_idx;
  wire logic r_in_ch;
  wire logic r_is_glob;
  wire logic r_hit;
  logic [31:0] rd_mux;
  logic [31:0] live_word;

  assign r_ch = s_axi_araddr[7:5];
  assign r_idx = s_axi_araddr[4:2];
  assign r_in_ch = (s_axi_araddr[11:8] == 4'h0) && (32'(r_ch) < NUM_CH) &&
    ((r_idx == `VAM_IDX_XMAP) || (r_idx == `VAM_IDX_RDI));
  assign r_is_glob = s_axi_araddr[11:4] == `VAM_GLOBAL_PAGE;
  assign r_hit = r_in_ch | r_is_glob;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (r_in_ch && (r_idx == `VAM_IDX_XMAP)) begin
      rd_mux = {24'h00_0000, xmap_r[r_ch]};
    end else if (r_in_ch) begin
      rd_mux = {24'h00_0000, rdi_r[r_ch]};
    end else if (r_is_glob) begin
      unique case (s_axi_araddr[3:2])
        `VAM_OFS_MODE: rd_mux = mode_r;
        `VAM_OFS_STATUS: rd_mux = {8'h00, status_r};
        `VAM_OFS_MASK: rd_mux = {8'h00, mask_r};
        `VAM_OFS_LIVE: rd_mux = live_word;
      endcase
    end
  end

  // Live outputs for software: ds1 AIS, VT AIS, yellow, one bit per channel
  always_comb begin
    live_word = 32'h0000_0000;
    live_word[`VAM_ST_YEL_LSB +: NUM_CH] = yellow_tx;
    live_word[`VAM_ST_VAIS_LSB +: NUM_CH] = vt_ais;
    live_word[`VAM_ST_DAIS_LSB +: NUM_CH] = ds1_ais;
  end

  // AXI write handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= vam_pkg::VAM_RESP_OKAY;
    end else begin
      if (aw_take) begin
        s_axi_awready <= 1'b0;
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        s_axi_wready <= 1'b0;
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_hit ? vam_pkg::VAM_RESP_OKAY : vam_pkg::VAM_RESP_SLVERR;
      end
      if (b_done) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI read handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= vam_pkg::VAM_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= r_hit ? vam_pkg::VAM_RESP_OKAY : vam_pkg::VAM_RESP_SLVERR;
    end else if (r_done) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Global mode and mask registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= `VAM_MODE_RST;
      mask_r <= '0;
    end else if (do_write) begin
      if (w_mode) begin
        mode_r <= (mode_r & ~wmask) | wbits;
      end
      if (w_mask) begin
        mask_r <= (mask_r & ~wmask[`VAM_ST_W-1:0]) | wbits[`VAM_ST_W-1:0];
      end
    end
  end

  // Per-channel datapath
  logic [NUM_CH-1:0] yel_nxt;
  logic [NUM_CH-1:0] rfi_nxt;
  logic [NUM_CH-1:0] vais_nxt;
  logic [NUM_CH-1:0] dais_nxt;
  logic [3*NUM_CH-1:0] rdi_nxt;

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      // Control bits of this channel only
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          xmap_r[c] <= `VAM_XMAP_RST;
          rdi_r[c] <= `VAM_RDI_RST;
        end else if (do_write && (32'(w_ch) == c)) begin
          if (w_xmap && wstrb_r[0]) begin
            xmap_r[c] <= wdata_r[7:0] & `VAM_XMAP_WMASK;
          end
          if (w_rdi && wstrb_r[0]) begin
            rdi_r[c] <= wdata_r[7:0] & `VAM_RDI_WMASK;
          end
        end
      end

      vam_chan_map u_map (
        .datacom(mode_r[`VAM_MODE_DCOM_LSB + c]),
        .byte_sync(mode_r[`VAM_MODE_BSYNC_LSB + c]),
        .xmap(xmap_r[c]),
        .rdi_ctrl(rdi_r[c]),
        .rfi_rx(rfi_rx[c]),
        .yellow_rx(yellow_rx[c]),
        .line_ais_det(line_ais_det[c]),
        .label_mismatch(label_mismatch[c]),
        .auto_rdi(auto_rdi[3*c +: 3]),
        .yellow_tx(yel_nxt[c]),
        .rfi_ins(rfi_nxt[c]),
        .vt_ais(vais_nxt[c]),
        .ds1_ais(dais_nxt[c]),
        .rdi_code(rdi_nxt[3*c +: 3])
      );

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          yellow_tx[c] <= 1'b0;
          rfi_ins[c] <= 1'b0;
          vt_ais[c] <= 1'b0;
          ds1_ais[c] <= 1'b0;
          rdi_code[3*c +: 3] <= `VAM_RDI_CODE_NONE;
        end else begin
          yellow_tx[c] <= yel_nxt[c];
          rfi_ins[c] <= rfi_nxt[c];
          vt_ais[c] <= vais_nxt[c];
          ds1_ais[c] <= dais_nxt[c];
          rdi_code[3*c +: 3] <= rdi_nxt[3*c +: 3];
        end
      end
    end
  endgenerate

  // Sticky events on rising yellow, VT AIS and DS1 AIS outputs; a set beats a same-cycle clear
  logic [`VAM_ST_W-1:0] ev_set;
  logic [`VAM_ST_W-1:0] ev_clr;
  logic [`VAM_ST_W-1:0] status_nxt;

  always_comb begin
    ev_set = '0;
    ev_set[`VAM_ST_YEL_LSB +: NUM_CH] = yel_nxt & ~yellow_tx;
    ev_set[`VAM_ST_VAIS_LSB +: NUM_CH] = vais_nxt & ~vt_ais;
    ev_set[`VAM_ST_DAIS_LSB +: NUM_CH] = dais_nxt & ~ds1_ais;
    ev_clr = (do_write && w_stat) ? wbits[`VAM_ST_W-1:0] : '0;
    status_nxt = (status_r & ~ev_clr) | ev_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
      irq <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq <= |(status_nxt & mask_r);
    end
  end

endmodule

// *** dv/vam_alarm_map_monitor.sv ***
// Concurrent checks on the alarm mapping bank ports.
// Assumes one clock aclk and synchronous active-low aresetn.
`timescale 1ns/1ps
`include "vam_defines.svh"
module vam_alarm_map_monitor #(
  parameter int NUM_CH = 7
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_CH-1:0] rfi_rx,
  input wire logic [NUM_CH-1:0] yellow_rx,
  input wire logic [NUM_CH-1:0] line_ais_det,
  input wire logic [NUM_CH-1:0] label_mismatch,
  input wire logic [3*NUM_CH-1:0] auto_rdi,
  input wire logic [NUM_CH-1:0] yellow_tx,
  input wire logic [NUM_CH-1:0] rfi_ins,
  input wire logic [NUM_CH-1:0] vt_ais,
  input wire logic [NUM_CH-1:0] ds1_ais,
  input wire logic [3*NUM_CH-1:0] rdi_code
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_yellow_cause: assert property ((yellow_tx & ~$past(rfi_rx)) == '0)
    else $error("yellow sent without rfi");
  chk_rfi_cause: assert property ((rfi_ins & ~$past(yellow_rx)) == '0)
    else $error("rfi inserted without yellow");
  chk_vais_cause: assert property ((vt_ais & ~$past(line_ais_det)) == '0)
    else $error("vt ais without line ais");
  chk_dais_cause: assert property ((ds1_ais & ~$past(label_mismatch)) == '0)
    else $error("ds1 ais without mismatch");
  chk_rdi_forced: assert property ($past(aresetn) && rdi_code[5:3] != $past(auto_rdi[5:3])
    |-> rdi_code[5:3] inside {`VAM_RDI_CODE_NONE, `VAM_RDI_CODE_PD, `VAM_RDI_CODE_SD,
    `VAM_RDI_CODE_CD})
    else $error("rdi code neither auto nor forced");
  chk_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready stayed high after take");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind vam_alarm_map vam_alarm_map_monitor #(.NUM_CH(NUM_CH)) u_mon (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .rfi_rx, .yellow_rx, .line_ais_det, .label_mismatch, .auto_rdi,
  .yellow_tx, .rfi_ins, .vt_ais, .ds1_ais, .rdi_code);

// *** dv/vam_alarm_map_tb.sv ***
// Self-checking bench for the alarm mapping bank over AXI4-Lite.
// Assumes the bound monitor; clock 100 MHz.
`timescale 1ns/1ps
`include "vam_defines.svh"
module vam_alarm_map_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wrd, bv, arr, rv, irq;
  logic [31:0] wd = 32'h0, rd;
  logic [1:0] br, rr;
  logic [6:0] rfi = 7'h00, yel = 7'h00, lais = 7'h00, slm = 7'h00, ytx, rins, vais, dais;
  logic [20:0] arc = 21'h0, rdc;
  int errors = 0;
  int tests_run = 0;
  always #5 aclk = ~aclk;
  vam_alarm_map u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .rfi_rx(rfi), .yellow_rx(yel), .line_ais_det(lais), .label_mismatch(slm),
    .auto_rdi(arc), .yellow_tx(ytx), .rfi_ins(rins), .vt_ais(vais), .ds1_ais(dais),
    .rdi_code(rdc), .irq(irq));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ta, tw, tb;
    logic [1:0] b;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awv & awr;
      tw = wv & wrd;
      tb = bv & bry;
      b = br;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) bry <= 1'b0;
    end while (!tb);
    chk("bresp", {30'h0, e}, {30'h0, b});
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arv & arr;
      tr = rv & rry;
      d = rd;
      r = rr;
      @(posedge aclk);
      if (ta) arv <= 1'b0;
      if (tr) rry <= 1'b0;
    end while (!tr);
    chk("rdata", e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic settle;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic t_reset;
    @(negedge aclk);
    chk("rdi_code", {7{`VAM_RDI_CODE_NONE}}, rdc);
    chk("irq", 32'h0, irq);
    rdchk(12'h004, `VAM_XMAP_RST, 2'b00);
    rdchk(12'h008, `VAM_RDI_RST, 2'b00);
    rdchk(12'h0E4, 32'h0, 2'b10);
    wr(12'h0E4, 32'hFF, 2'b10);
  endtask
  task automatic t_cross;
    wr(12'h044, 32'h07, 2'b00);
    wr(12'h100, 32'h400, 2'b00);
    @(posedge aclk);
    rfi <= 7'h14;
    yel <= 7'h14;
    lais <= 7'h14;
    settle;
    chk("yellow_tx", 32'h04, ytx);
    chk("rfi_ins", 32'h04, rins);
    chk("vt_ais", 32'h04, vais);
    wr(12'h100, 32'h404, 2'b00);
    settle;
    chk("datacom", 32'h0, {ytx, rins, vais});
    rdchk(12'h044, 32'h07, 2'b00);
  endtask
  task automatic t_rdi;
    logic [7:0] req [3] = '{8'h80, 8'h40, 8'h20};
    logic [2:0] code [3] = '{`VAM_RDI_CODE_PD, `VAM_RDI_CODE_SD, `VAM_RDI_CODE_CD};
    @(posedge aclk);
    arc <= {7{3'h3}};
    for (int i = 0; i < 3; i++) begin
      wr(12'h028, {24'h0, req[i] | 8'h08}, 2'b00);
      settle;
      chk("rdi_code", {{5{3'h3}}, code[i], 3'h3}, rdc);
    end
    wr(12'h028, 32'hE4, 2'b00);
    // Unequipped channel 3: mismatch to AIS on, no RDI requests
    wr(12'h068, 32'h04, 2'b00);
    @(posedge aclk);
    slm <= 7'h0A;
    settle;
    chk("auto rdi", {7{3'h3}}, rdc);
    chk("ds1_ais", 32'h0A, dais);
    rdchk(12'h028, 32'hE4, 2'b00);
  endtask
  task automatic t_irq;
    rdchk(12'h104, 32'hA0404, 2'b00);
    chk("irq masked", 32'h0, irq);
    wr(12'h108, 32'h20000, 2'b00);
    settle;
    chk("irq", 32'h1, irq);
    wr(12'h104, 32'hFFFFFF, 2'b00);
    settle;
    chk("irq cleared", 32'h0, irq);
    rdchk(12'h104, 32'h0, 2'b00);
  endtask
  task automatic report_and_stop;
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_cross;
    t_rdi;
    t_irq;
    report_and_stop;
  end
  initial begin
    #20000;
    errors++;
    report_and_stop;
  end
endmodule
